// ===== design/pnpp_top.sv
`timescale 1ns/1ps
`include "pnpp_map.svh"
module pnpp_top #(
    parameter int FLASH_WORDS = 4096,
    parameter int FLASH_PAGE_WORDS = 32,
    parameter int EE_BYTES = 512,
    parameter int EE_PAGE_BYTES = 4,
    parameter int T_FLASH_CYC = `PNPP_T_FLASH_CYC,
    parameter int T_EE_CYC = `PNPP_T_EE_CYC,
    parameter int T_ERASE_CYC = `PNPP_T_ERASE_CYC,
    parameter int T_FUSE_CYC = `PNPP_T_FUSE_CYC,
    // identification values are arbitrary
    parameter logic [7:0] SIG_BYTE0 = 8'h5a,
    parameter logic [7:0] SIG_BYTE1 = 8'h01,
    parameter logic [7:0] SIG_BYTE2 = 8'h02,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_load_strobe_pin,
    input wire logic i_page_latch_strobe,
    input wire logic i_write_strobe_n,
    input wire logic i_output_enable_n,
    input wire logic i_action_select_hi,
    input wire logic i_action_select_lo,
    input wire logic i_byte_select_one,
    input wire logic i_byte_select_two,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    output logic o_ready_busy_flag
);
    localparam int FAW = $clog2(FLASH_WORDS);
    localparam int FPW = $clog2(FLASH_PAGE_WORDS);
    localparam int EAW = $clog2(EE_BYTES);
    localparam int EPW = $clog2(EE_PAGE_BYTES);

    // =========================================================
    // parameter checks
    if (FLASH_WORDS > 32768 || FLASH_WORDS < 2 * FLASH_PAGE_WORDS) begin : g_bad_flash
        $error("pnpp_top: flash size out of range");
    end
    if (FLASH_PAGE_WORDS > 256 || FLASH_PAGE_WORDS < 2) begin : g_bad_fpage
        $error("pnpp_top: flash page must be 2 to 256 words");
    end
    if (EE_BYTES > FLASH_WORDS || EE_BYTES > 65536 || EE_PAGE_BYTES < 2) begin : g_bad_ee
        $error("pnpp_top: eeprom geometry not supported");
    end
    if (T_FLASH_CYC < FLASH_PAGE_WORDS || T_EE_CYC < EE_PAGE_BYTES) begin : g_bad_tprog
        $error("pnpp_top: programming time shorter than page walk");
    end
    if (T_ERASE_CYC < FLASH_WORDS || T_FUSE_CYC < 1) begin : g_bad_terase
        $error("pnpp_top: erase or fuse time too short");
    end

    // =========================================================
    // pin synchroniser
    pnpp_pins_if pins ();

    pnpp_sync #(
        .W(`PNPP_PIN_W)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_pins({i_data, i_byte_select_two, i_byte_select_one, i_action_select_lo,
            i_action_select_hi, i_output_enable_n, i_write_strobe_n,
            i_page_latch_strobe, i_load_strobe_pin}),
        .pins(pins)
    );

    // =========================================================
    // address decoding
    function automatic logic [FAW-1:0] flash_addr(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] full;
        full = {hi, lo};
        return full[FAW-1:0];
    endfunction

    function automatic logic [EAW-1:0] ee_addr(input logic [7:0] hi, input logic [7:0] lo);
        logic [15:0] full;
        full = {hi, lo};
        return full[EAW-1:0];
    endfunction

    // =========================================================
    // memories
    logic [15:0] flash_mem [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [15:0] flash_buf [FLASH_PAGE_WORDS];
    logic [7:0] ee_buf [EE_PAGE_BYTES];

    pnpp_pkg::pnpp_regs_t r;
    pnpp_pkg::pnpp_regs_t next_r;

    logic ls_rise;
    logic pl_rise;
    logic wr_fall;
    logic idle;
    logic [1:0] act;
    logic [FAW-1:0] cur_faddr;
    logic [EAW-1:0] cur_eaddr;
    logic fw_en;
    logic [FAW-1:0] fw_addr;
    logic [15:0] fw_data;
    logic ew_en;
    logic [EAW-1:0] ew_addr;
    logic [7:0] ew_data;
    logic fbuf_we;
    logic ebuf_we;
    logic buf_clr;
    logic [15:0] flash_rd;
    logic [7:0] lock_keep;

    assign cur_faddr = flash_addr(r.addr_hi, r.addr_lo);
    assign cur_eaddr = ee_addr(r.addr_hi, r.addr_lo);
    assign flash_rd = flash_mem[cur_faddr];

    always_ff @(posedge i_core_clk) begin
        if (fw_en) begin
            flash_mem[fw_addr] <= fw_data;
        end
        if (ew_en) begin
            ee_mem[ew_addr] <= ew_data;
        end
        if (buf_clr) begin
            for (int i = 0; i < FLASH_PAGE_WORDS; i++) begin
                flash_buf[i] <= `PNPP_WORD_ERASED;
            end
            for (int j = 0; j < EE_PAGE_BYTES; j++) begin
                ee_buf[j] <= `PNPP_BYTE_ERASED;
            end
        end else begin
            if (fbuf_we) begin
                flash_buf[r.addr_lo[FPW-1:0]] <= {r.data_hi, r.data_lo}; // R5
            end
            if (ebuf_we) begin
                ee_buf[r.addr_lo[EPW-1:0]] <= r.data_lo; // R9
            end
        end
    end

    // =========================================================
    // command, load and programming control
    always_comb begin
        next_r = r;
        ls_rise = pins.load_strobe && !r.prev_ls;
        pl_rise = pins.page_latch && !r.prev_pl;
        wr_fall = !pins.write_n && r.prev_wr;
        idle = (r.state == pnpp_pkg::PNPP_IDLE);
        act = {pins.act_hi, pins.act_lo};
        fw_en = 1'b0;
        fw_addr = cur_faddr;
        fw_data = `PNPP_WORD_ERASED;
        ew_en = 1'b0;
        ew_addr = cur_eaddr;
        ew_data = `PNPP_BYTE_ERASED;
        fbuf_we = 1'b0;
        ebuf_we = 1'b0;
        buf_clr = 1'b0;
        lock_keep = ((r.lock & `PNPP_LOCK_MODE_MASK) == 8'h00) ? `PNPP_BOOT_LOCK_MASK : 8'h00;
        next_r.prev_ls = pins.load_strobe;
        next_r.prev_pl = pins.page_latch;
        next_r.prev_wr = pins.write_n;

        if (ls_rise && idle) begin
            case (act)
                `PNPP_ACT_ADDR: begin
                    if (pins.bs1) begin
                        next_r.addr_hi = pins.data; // R3
                    end else begin
                        next_r.addr_lo = pins.data; // R2
                    end
                end
                `PNPP_ACT_DATA: begin
                    if (pins.bs1) begin
                        next_r.data_hi = pins.data; // R4
                    end else begin
                        next_r.data_lo = pins.data; // R4
                    end
                end
                `PNPP_ACT_CMD: begin
                    next_r.cmd = pins.data; // R1
                    if (pins.data == `PNPP_CMD_NOOP) begin
                        next_r.data_lo = `PNPP_BYTE_ERASED; // R8
                        next_r.data_hi = `PNPP_BYTE_ERASED; // R8
                        buf_clr = 1'b1; // R8
                    end
                end
                default: begin
                end // R21
            endcase
        end

        if (pl_rise && idle) begin
            if (r.cmd == `PNPP_CMD_WR_FLASH && pins.bs1) begin
                fbuf_we = 1'b1; // R5
            end
            if (r.cmd == `PNPP_CMD_WR_EE) begin
                ebuf_we = 1'b1; // R9
            end
        end

        case (r.state)
            pnpp_pkg::PNPP_IDLE: begin
                if (wr_fall) begin
                    next_r.idx = 16'h0000;
                    case (r.cmd)
                        `PNPP_CMD_WR_FLASH: begin
                            next_r.state = pnpp_pkg::PNPP_PROG_FLASH; // R7
                            next_r.wait_cnt = 32'(T_FLASH_CYC);
                        end
                        `PNPP_CMD_WR_EE: begin
                            if (!pins.bs1) begin
                                next_r.state = pnpp_pkg::PNPP_PROG_EE; // R9
                                next_r.wait_cnt = 32'(T_EE_CYC);
                            end
                        end
                        `PNPP_CMD_WR_FUSE: begin
                            case ({pins.bs2, pins.bs1})
                                2'h0: next_r.fuse_lo = r.data_lo; // R12
                                2'h1: next_r.fuse_hi = r.data_lo; // R13
                                2'h2: next_r.fuse_ext = r.data_lo; // R13
                                default: next_r.fuse_lo = r.fuse_lo;
                            endcase
                            next_r.state = pnpp_pkg::PNPP_SETTLE;
                            next_r.wait_cnt = 32'(T_FUSE_CYC);
                        end
                        `PNPP_CMD_WR_LOCK: begin
                            next_r.lock = r.lock & (r.data_lo | lock_keep); // R14 R15
                            next_r.state = pnpp_pkg::PNPP_SETTLE;
                            next_r.wait_cnt = 32'(T_FUSE_CYC);
                        end
                        `PNPP_CMD_ERASE: begin
                            next_r.state = pnpp_pkg::PNPP_ERASE; // R20
                            next_r.wait_cnt = 32'(T_ERASE_CYC);
                        end
                        default: begin
                            next_r.state = pnpp_pkg::PNPP_IDLE;
                        end
                    endcase
                end
            end
            pnpp_pkg::PNPP_PROG_FLASH: begin
                if (32'(r.idx) < FLASH_PAGE_WORDS) begin
                    fw_en = 1'b1;
                    fw_addr = {cur_faddr[FAW-1:FPW], r.idx[FPW-1:0]}; // R6
                    fw_data = flash_buf[r.idx[FPW-1:0]]; // R7
                    next_r.idx = r.idx + 16'h0001;
                end
            end
            pnpp_pkg::PNPP_PROG_EE: begin
                if (32'(r.idx) < EE_PAGE_BYTES) begin
                    ew_en = 1'b1;
                    ew_addr = {cur_eaddr[EAW-1:EPW], r.idx[EPW-1:0]}; // R6
                    ew_data = ee_buf[r.idx[EPW-1:0]]; // R9
                    next_r.idx = r.idx + 16'h0001;
                end
            end
            pnpp_pkg::PNPP_ERASE: begin
                if (32'(r.idx) < FLASH_WORDS) begin
                    fw_en = 1'b1; // R19
                    fw_addr = r.idx[FAW-1:0];
                    next_r.idx = r.idx + 16'h0001;
                end
                if (32'(r.idx) < EE_BYTES) begin
                    ew_en = 1'b1; // R19
                    ew_addr = r.idx[EAW-1:0];
                end
            end
            default: begin
            end
        endcase

        if (r.state != pnpp_pkg::PNPP_IDLE) begin
            next_r.wait_cnt = r.wait_cnt - 32'h00000001;
            if (r.wait_cnt <= 32'h00000001) begin
                next_r.state = pnpp_pkg::PNPP_IDLE; // R7 R20
                if (r.state == pnpp_pkg::PNPP_ERASE) begin
                    next_r.lock = `PNPP_LOCK_RST; // R15
                end
                if (r.state == pnpp_pkg::PNPP_PROG_FLASH || r.state == pnpp_pkg::PNPP_PROG_EE) begin
                    buf_clr = 1'b1;
                end
            end
        end

        // =========================================================
        // read-back mux
        next_r.dout = `PNPP_BYTE_ERASED;
        case (r.cmd)
            `PNPP_CMD_RD_FLASH: begin
                next_r.dout = pins.bs1 ? flash_rd[15:8] : flash_rd[7:0]; // R10
            end
            `PNPP_CMD_RD_EE: begin
                if (!pins.bs1) begin
                    next_r.dout = ee_mem[cur_eaddr]; // R11
                end
            end
            `PNPP_CMD_RD_FUSE: begin
                case ({pins.bs2, pins.bs1})
                    2'h0: next_r.dout = r.fuse_lo; // R16
                    2'h3: next_r.dout = r.fuse_hi; // R16
                    2'h2: next_r.dout = r.fuse_ext; // R16
                    default: next_r.dout = r.lock; // R16
                endcase
            end
            `PNPP_CMD_RD_SIG: begin
                if (pins.bs1) begin
                    if (r.addr_lo == `PNPP_CAL_ADDR) begin
                        next_r.dout = CAL_BYTE; // R18
                    end
                end else begin
                    case (r.addr_lo)
                        8'h00: next_r.dout = SIG_BYTE0; // R17
                        8'h01: next_r.dout = SIG_BYTE1; // R17
                        `PNPP_SIG_LAST: next_r.dout = SIG_BYTE2; // R17
                        default: next_r.dout = `PNPP_BYTE_ERASED;
                    endcase
                end
            end
            default: begin
                next_r.dout = `PNPP_BYTE_ERASED;
            end
        endcase
        next_r.doe = !pins.oe_n; // R22
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r.state <= pnpp_pkg::PNPP_IDLE;
            r.cmd <= `PNPP_CMD_NOOP;
            r.addr_lo <= 8'h00;
            r.addr_hi <= 8'h00;
            r.data_lo <= `PNPP_BYTE_ERASED;
            r.data_hi <= `PNPP_BYTE_ERASED;
            r.fuse_lo <= `PNPP_FUSE_LO_RST;
            r.fuse_hi <= `PNPP_FUSE_HI_RST;
            r.fuse_ext <= `PNPP_FUSE_EXT_RST;
            r.lock <= `PNPP_LOCK_RST;
            r.wait_cnt <= 32'h00000000;
            r.idx <= 16'h0000;
            r.prev_ls <= 1'b0;
            r.prev_pl <= 1'b0;
            r.prev_wr <= 1'b1;
            r.dout <= 8'h00;
            r.doe <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign o_data = r.dout;
    assign o_data_oe = r.doe; // R22
    assign o_ready_busy_flag = (r.state == pnpp_pkg::PNPP_IDLE); // R7 R9 R12 R20
endmodule

// ===== design/pnpp_map.svh
// How it works
// R1: pins 10 with byte_select_one low and a load strobe store the command byte.
// R2: pins 00, byte_select_one low, load strobe store any low address byte.
// R3: pins 00, byte_select_one high, load strobe store the high address byte.
// R4: pins 01 with load strobe store data; byte_select_one picks low or high.
// R5: page latch strobe with byte_select_one high fills the flash buffer word.
// R6: low address bits pick the word, upper bits pick the page.
// R7: write flash command, then write strobe programs the page while busy.
// R8: the no-operation command clears the internal write state.
// R9: write eeprom command, latched bytes, write strobe with select low programs.
// R10: read flash command drives the low or high byte of the word.
// R11: read eeprom command drives the addressed byte.
// R12: write fuse command, data byte, write strobe; zero bits program fuses.
// R13: byte selects pick the low, high or extended fuse byte on write.
// R14: write lock command programs zero bits; lock mode 3 freezes boot locks.
// R15: only a chip erase or a reset clears programmed lock bits.
// R16: read fuse and lock command drives the byte chosen by both selects.
// R17: read signature command drives signature byte 0 to 2.
// R18: read signature at address zero with select high drives calibration.
// R19: chip erase leaves every flash and eeprom location reading 0xff.
// R20: erase command and write strobe start a chip erase while busy.
// R21: a load strobe with both action pins high does nothing.
// R22: the data bus is driven only while output enable is low.
`ifndef PNPP_MAP_SVH
`define PNPP_MAP_SVH

`define PNPP_ACT_ADDR 2'h0
`define PNPP_ACT_DATA 2'h1
`define PNPP_ACT_CMD 2'h2

`define PNPP_CMD_NOOP 8'h00
`define PNPP_CMD_ERASE 8'h80
`define PNPP_CMD_WR_FUSE 8'h40
`define PNPP_CMD_WR_LOCK 8'h20
`define PNPP_CMD_WR_FLASH 8'h10
`define PNPP_CMD_WR_EE 8'h11
`define PNPP_CMD_RD_SIG 8'h08
`define PNPP_CMD_RD_FUSE 8'h04
`define PNPP_CMD_RD_FLASH 8'h02
`define PNPP_CMD_RD_EE 8'h03

`define PNPP_BYTE_ERASED 8'hff
`define PNPP_WORD_ERASED 16'hffff
`define PNPP_FUSE_LO_RST 8'hff
`define PNPP_FUSE_HI_RST 8'hff
`define PNPP_FUSE_EXT_RST 8'hff
`define PNPP_LOCK_RST 8'hff
`define PNPP_LOCK_MODE_MASK 8'h03
`define PNPP_BOOT_LOCK_MASK 8'h3c
`define PNPP_SIG_LAST 8'h02
`define PNPP_CAL_ADDR 8'h00

`define PNPP_PIN_W 16
`define PNPP_PIN_RST 16'h000c

`define PNPP_CLK_PERIOD_NS 20
`define PNPP_T_WD_FLASH_NS 4500000
`define PNPP_T_WD_EEPROM_NS 3600000
`define PNPP_T_WD_ERASE_NS 9000000
`define PNPP_T_WD_FUSE_NS 4500000
`define PNPP_T_FLASH_CYC ((`PNPP_T_WD_FLASH_NS + `PNPP_CLK_PERIOD_NS - 1) / `PNPP_CLK_PERIOD_NS)
`define PNPP_T_EE_CYC ((`PNPP_T_WD_EEPROM_NS + `PNPP_CLK_PERIOD_NS - 1) / `PNPP_CLK_PERIOD_NS)
`define PNPP_T_ERASE_CYC ((`PNPP_T_WD_ERASE_NS + `PNPP_CLK_PERIOD_NS - 1) / `PNPP_CLK_PERIOD_NS)
`define PNPP_T_FUSE_CYC ((`PNPP_T_WD_FUSE_NS + `PNPP_CLK_PERIOD_NS - 1) / `PNPP_CLK_PERIOD_NS)

`endif

// ===== design/pnpp_pkg.sv
package pnpp_pkg;

    typedef enum logic [2:0] {
        PNPP_IDLE,
        PNPP_PROG_FLASH,
        PNPP_PROG_EE,
        PNPP_ERASE,
        PNPP_SETTLE
    } pnpp_state_t;

    typedef struct packed {
        pnpp_state_t state;
        logic [7:0] cmd;
        logic [7:0] addr_lo;
        logic [7:0] addr_hi;
        logic [7:0] data_lo;
        logic [7:0] data_hi;
        logic [7:0] fuse_lo;
        logic [7:0] fuse_hi;
        logic [7:0] fuse_ext;
        logic [7:0] lock;
        logic [31:0] wait_cnt;
        logic [15:0] idx;
        logic prev_ls;
        logic prev_pl;
        logic prev_wr;
        logic [7:0] dout;
        logic doe;
    } pnpp_regs_t;

    typedef struct packed {
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] filt;
    } pnpp_sync_t;

endpackage

// ===== design/pnpp_pins_if.sv
`timescale 1ns/1ps
interface pnpp_pins_if;
    logic load_strobe;
    logic page_latch;
    logic write_n;
    logic oe_n;
    logic act_hi;
    logic act_lo;
    logic bs1;
    logic bs2;
    logic [7:0] data;
    modport src (output load_strobe, page_latch, write_n, oe_n, act_hi, act_lo, bs1, bs2, data);
    modport dst (input load_strobe, page_latch, write_n, oe_n, act_hi, act_lo, bs1, bs2, data);
endinterface

// ===== design/pnpp_sync.sv
`timescale 1ns/1ps
`include "pnpp_map.svh"
module pnpp_sync #(
    parameter int W = `PNPP_PIN_W
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_pins,
    pnpp_pins_if.src pins
);
    if (W != `PNPP_PIN_W) begin : g_bad_width
        $error("pnpp_sync: pin width must match the state record");
    end

    pnpp_pkg::pnpp_sync_t r;
    pnpp_pkg::pnpp_sync_t next_r;
    logic [15:0] agree;

    // =========================================================
    // three stages, level accepted once stages two and three agree
    always_comb begin
        agree = ~(r.s2 ^ r.s3);
        next_r = r;
        next_r.s1 = i_pins;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.filt = (agree & r.s3) | (~agree & r.filt);
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= {4{`PNPP_PIN_RST}};
        end else begin
            r <= next_r;
        end
    end

    assign pins.load_strobe = r.filt[0];
    assign pins.page_latch = r.filt[1];
    assign pins.write_n = r.filt[2];
    assign pins.oe_n = r.filt[3];
    assign pins.act_hi = r.filt[4];
    assign pins.act_lo = r.filt[5];
    assign pins.bs1 = r.filt[6];
    assign pins.bs2 = r.filt[7];
    assign pins.data = r.filt[15:8];
endmodule

// ===== sim/pnpp_asserts.sv
`timescale 1ns/1ps
// ==========
// port checker
module pnpp_asserts #(
    parameter int T_ERASE_CYC = 4096
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_load_strobe_pin,
    input wire logic i_page_latch_strobe,
    input wire logic i_write_strobe_n,
    input wire logic i_output_enable_n,
    input wire logic i_action_select_hi,
    input wire logic i_action_select_lo,
    input wire logic i_byte_select_one,
    input wire logic i_byte_select_two,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic o_ready_busy_flag
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic [3:0] since_wr;
    logic [31:0] busy_cnt;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            since_wr <= 4'h0;
            busy_cnt <= 32'h0;
        end else begin
            since_wr <= !i_write_strobe_n ? 4'h0 : (since_wr == 4'hf ? since_wr : since_wr + 4'h1);
            busy_cnt <= o_ready_busy_flag ? 32'h0 : busy_cnt + 32'h1;
        end
    end
    sequence busy_start_s;
        $fell(o_ready_busy_flag);
    endsequence
    sequence quiet_s;
        (i_action_select_hi && i_action_select_lo && !i_page_latch_strobe && i_write_strobe_n
            && o_ready_busy_flag
            && $stable({i_byte_select_one, i_byte_select_two, i_output_enable_n}))[*8];
    endsequence
    oe_on_a: assert property (!i_output_enable_n [*8] |-> o_data_oe)
        else $error("bus not driven while enabled");
    oe_off_a: assert property (i_output_enable_n [*8] |-> !o_data_oe)
        else $error("bus driven while disabled");
    oe_rise_a: assert property ($rose(o_data_oe) |-> !i_output_enable_n)
        else $error("drive began without enable");
    oe_fall_a: assert property ($fell(o_data_oe) |-> i_output_enable_n)
        else $error("drive ended with enable low");
    busy_min_a: assert property (busy_start_s |-> !o_ready_busy_flag [*4])
        else $error("busy too short");
    busy_max_a: assert property (int'(busy_cnt) <= T_ERASE_CYC + 4)
        else $error("busy too long");
    busy_cause_a: assert property (busy_start_s |-> since_wr <= 4'h8)
        else $error("busy without write strobe");
    load_idle_a: assert property (quiet_s |-> $stable(o_data))
        else $error("idle load changed read data");
endmodule

// ===== sim/pnpp_prog_model.sv
`timescale 1ns/1ps
// ==========
// programmer model
module pnpp_prog_model (
    input wire logic i_core_clk,
    input wire logic i_ready_busy_flag,
    output logic o_load,
    output logic o_page,
    output logic o_wr_n,
    output logic o_oe_n,
    output logic [1:0] o_act,
    output logic o_bs1,
    output logic o_bs2,
    output logic [7:0] o_data,
    output logic o_look
);
    initial begin
        {o_load, o_page, o_look, o_bs1, o_bs2, o_act, o_data} = '0;
        {o_wr_n, o_oe_n} = 2'h3;
    end
    task automatic step();
        repeat (6) @(posedge i_core_clk);
    endtask
    task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
        o_act <= act;
        o_bs1 <= bs1;
        o_bs2 <= 1'b0;
        o_data <= d;
        step();
        o_load <= 1'b1;
        step();
        o_load <= 1'b0;
        step();
    endtask
    task automatic latch();
        o_bs1 <= 1'b1;
        step();
        o_page <= 1'b1;
        step();
        o_page <= 1'b0;
        step();
    endtask
    task automatic write(input logic bs1, input logic bs2);
        int n = 0;
        o_bs1 <= bs1;
        o_bs2 <= bs2;
        step();
        o_wr_n <= 1'b0;
        step();
        testbench.check(8'(i_ready_busy_flag), 8'h00);
        o_wr_n <= 1'b1;
        step();
        while (!i_ready_busy_flag && n < 5000) begin
            @(posedge i_core_clk);
            n++;
        end
        testbench.check(8'(i_ready_busy_flag), 8'h01);
        step();
    endtask
    task automatic rd(input logic bs2, input logic bs1);
        o_oe_n <= 1'b0;
        o_bs1 <= bs1;
        o_bs2 <= bs2;
        o_data <= ~o_data;
        repeat (2) step();
        o_look <= 1'b1;
        @(posedge i_core_clk);
        o_look <= 1'b0;
        o_oe_n <= 1'b1;
        step();
    endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
// ==========
// bench top
module testbench;
    localparam logic [7:0] SIG [3] = '{8'h6b, 8'h17, 8'h29}; // arbitrary
    localparam logic [7:0] CAL = 8'h4d; // arbitrary
    logic i_core_clk;
    logic i_rst_n;
    logic load, page, wr_n, oe_n, bs1, bs2, look, doe, rdy;
    logic [1:0] act;
    logic [7:0] din, dout;
    logic [7:0] d[4];
    logic [7:0] exp_q[$];
    int bad_count = 0, total_checks = 0;
    pnpp_top #(.T_FLASH_CYC(64), .T_EE_CYC(8), .T_ERASE_CYC(4096), .T_FUSE_CYC(4),
        .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL)) dut (
        .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_load_strobe_pin(load),
        .i_page_latch_strobe(page), .i_write_strobe_n(wr_n), .i_output_enable_n(oe_n),
        .i_action_select_hi(act[1]), .i_action_select_lo(act[0]), .i_byte_select_one(bs1),
        .i_byte_select_two(bs2), .i_data(din), .o_data(dout), .o_data_oe(doe),
        .o_ready_busy_flag(rdy));
    pnpp_prog_model prog (.i_core_clk(i_core_clk), .i_ready_busy_flag(rdy), .o_load(load),
        .o_page(page), .o_wr_n(wr_n), .o_oe_n(oe_n), .o_act(act), .o_bs1(bs1), .o_bs2(bs2),
        .o_data(din), .o_look(look));
    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        if (look === 1'b1) begin
            check(8'(doe), 8'h01);
            check(dout, exp_q.pop_front());
        end
    end
    task automatic read_ck(input logic bs2, input logic bs1, input logic [7:0] e);
        exp_q.push_back(e);
        prog.rd(bs2, bs1);
    endtask
    task automatic erase();
        prog.load(2'b10, 1'b0, 8'h80);
        prog.write(1'b0, 1'b0);
    endtask
    initial begin
        repeat (60000) @(posedge i_core_clk);
        bad_count++;
        final_report();
    end
    initial begin
        i_rst_n = 1'b0;
        void'($urandom(80));
        for (int i = 0; i < 4; i++)
            d[i] = 8'($urandom);
        repeat (8) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        prog.step();
        check(8'(rdy), 8'h01);
        prog.load(2'b10, 1'b0, 8'h04);
        for (int i = 0; i < 4; i++)
            read_ck(i[1], i[0], 8'hff);
        $display("test reset done");
        prog.load(2'b10, 1'b0, 8'h08);
        for (int i = 0; i < 3; i++) begin
            prog.load(2'b00, 1'b0, 8'(i));
            read_ck(1'b0, 1'b0, SIG[i]);
        end
        prog.load(2'b11, 1'b0, 8'h00);
        read_ck(1'b0, 1'b0, SIG[2]);
        prog.load(2'b00, 1'b0, 8'h00);
        read_ck(1'b0, 1'b1, CAL);
        $display("test signature done");
        erase();
        prog.load(2'b10, 1'b0, 8'h02);
        prog.load(2'b00, 1'b1, 8'h05);
        prog.load(2'b00, 1'b0, 8'he3);
        read_ck(1'b0, 1'b1, 8'hff);
        prog.load(2'b10, 1'b0, 8'h03);
        read_ck(1'b0, 1'b0, 8'hff);
        $display("test erase done");
        prog.load(2'b10, 1'b0, 8'h10);
        for (int i = 0; i < 2; i++) begin
            prog.load(2'b00, 1'b0, 8'he3 + 8'(i));
            prog.load(2'b01, 1'b0, d[2*i]);
            prog.load(2'b01, 1'b1, d[2*i+1]);
            prog.latch();
        end
        prog.load(2'b00, 1'b1, 8'h05);
        prog.write(1'b1, 1'b0);
        prog.load(2'b10, 1'b0, 8'h00);
        prog.load(2'b10, 1'b0, 8'h02);
        for (int i = 0; i < 2; i++) begin
            prog.load(2'b00, 1'b0, 8'he3 + 8'(i));
            read_ck(1'b0, 1'b0, d[2*i]);
            read_ck(1'b0, 1'b1, d[2*i+1]);
        end
        $display("test flash done");
        prog.load(2'b10, 1'b0, 8'h11);
        prog.load(2'b00, 1'b1, 8'h01);
        prog.load(2'b00, 1'b0, 8'h42);
        prog.load(2'b01, 1'b0, d[3]);
        prog.latch();
        prog.write(1'b0, 1'b0);
        prog.load(2'b10, 1'b0, 8'h03);
        read_ck(1'b0, 1'b0, d[3]);
        prog.load(2'b00, 1'b0, 8'h43);
        read_ck(1'b0, 1'b0, 8'hff);
        $display("test eeprom done");
        for (int i = 0; i < 3; i++) begin
            prog.load(2'b10, 1'b0, 8'h40);
            prog.load(2'b01, 1'b0, d[i]);
            prog.write(i == 1, i == 2);
        end
        prog.load(2'b10, 1'b0, 8'h20);
        prog.load(2'b01, 1'b0, 8'hfc);
        prog.write(1'b0, 1'b0);
        prog.load(2'b01, 1'b0, 8'hc3);
        prog.write(1'b0, 1'b0);
        prog.load(2'b10, 1'b0, 8'h04);
        read_ck(1'b0, 1'b0, d[0]);
        read_ck(1'b1, 1'b1, d[1]);
        read_ck(1'b1, 1'b0, d[2]);
        read_ck(1'b0, 1'b1, 8'hfc);
        erase();
        prog.load(2'b10, 1'b0, 8'h04);
        read_ck(1'b0, 1'b1, 8'hff);
        $display("test fuse lock done");
        final_report();
    end
endmodule
bind pnpp_top pnpp_asserts #(.T_ERASE_CYC(T_ERASE_CYC)) chk (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_load_strobe_pin(i_load_strobe_pin),
    .i_page_latch_strobe(i_page_latch_strobe), .i_write_strobe_n(i_write_strobe_n),
    .i_output_enable_n(i_output_enable_n), .i_action_select_hi(i_action_select_hi),
    .i_action_select_lo(i_action_select_lo), .i_byte_select_one(i_byte_select_one),
    .i_byte_select_two(i_byte_select_two), .o_data(o_data), .o_data_oe(o_data_oe),
    .o_ready_busy_flag(o_ready_busy_flag));
